// ===== design/alarm_cfg_pkg.sv
// Constants and carrier types for the alarm configuration register group.
// Assumes 16-bit holding registers addressed by their protocol register number.
package alarm_cfg_pkg;
	localparam logic [15:0] OFS_DISP_SRC   = 16'h0fb8;
	localparam logic [15:0] OFS_LED_CLEAR  = 16'h0fb9;
	localparam logic [15:0] OFS_A1_SRC     = 16'h0fba;
	localparam logic [15:0] OFS_A1_KIND    = 16'h0fbb;
	localparam logic [15:0] OFS_A1_ON_DLY  = 16'h0fbc;
	localparam logic [15:0] OFS_A1_OFF_DLY = 16'h0fbd;
	localparam logic [15:0] OFS_A1_REARM   = 16'h0fbe;
	localparam logic [15:0] OFS_A1_LATCH   = 16'h0fbf;
	localparam logic [15:0] OFS_RSVD_GAP   = 16'h0fc0;
	localparam logic [15:0] OFS_A2_SRC     = 16'h0fc1;

	localparam logic [15:0] RST_DISP_SRC   = 16'h1d55;
	localparam logic [15:0] RST_LED_CLEAR  = 16'h0000;
	localparam logic [15:0] RST_SRC        = 16'h0000;
	localparam logic [15:0] RST_KIND       = 16'h0000;
	localparam logic [15:0] RST_DELAY      = 16'h0000;
	localparam logic [15:0] RST_LATCH      = 16'h0001;

	localparam logic [15:0] MAX_FLAG       = 16'h0001;
	localparam logic [15:0] MAX_A1_SRC     = 16'h0010;
	localparam logic [15:0] MAX_A2_SRC     = 16'h000e;
	localparam logic [15:0] MAX_KIND       = 16'h0005;
	localparam logic [15:0] MAX_DELAY      = 16'h0384;
	localparam logic [15:0] MEAS_BASE      = 16'h1d4c;
	localparam logic [4:0]  SRC_DISP2      = 5'h0f;
	localparam logic [4:0]  SRC_CLOCK      = 5'h10;

	localparam int CLK_HZ      = 25_000_000;
	localparam int TICK_TIME_S = 1;
	localparam int SEC_CYCLES  = CLK_HZ * TICK_TIME_S;

	typedef struct packed {
		logic [15:0] meas_addr;
		logic        use_display2;
		logic        use_clock;
	} src_sel_t;

	typedef enum logic [2:0] {
		A_IDLE    = 3'b000,
		A_ON_WAIT = 3'b001,
		A_ACTIVE  = 3'b010,
		A_OFF_WAIT= 3'b011,
		A_LOCK    = 3'b100
	} alarm_state_t;
endpackage

// ===== design/alarm_config_registers.sv
// Alarm and lower-display configuration registers with the alarm 1 timer.
// Assumes a protocol engine on CORE_CLK issuing single-cycle read/write
// strobes, and an alarm 1 trigger level from comparator logic on CORE_CLK.
//
// Summary of operation
// - Display source register, default 7509, names measurement shown on lower line.
// - Writing 1 to indication reset clears the alarm 1 held LED and pulses LED_CLEAR.
// - Alarm 1 source selector holds codes 0 to 16, default 0.
// - Codes 0-14 map to register 7500+code; 15 second display; 16 clock.
// - Alarm 1 asserts after programmable 0-900 s on delay.
// - Alarm 1 releases after off delay, then re-arm lock blocks reassertion.
// - Latch set keeps alarm 1 LED flashing after alarm until cleared.
// - Alarm 2 source selector holds codes 0 to 14, same mapping.
`timescale 1ns/1ps
module alarm_config_registers
	import alarm_cfg_pkg::*;
#(
	parameter int SEC_CYC = SEC_CYCLES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	output logic      [15:0] REG_RDATA,
	output logic             REG_ACK,
	output logic             REG_ERR,
	input  wire logic        ALARM1_TRIGGER,
	output logic             ALARM1_RELAY,
	output logic             ALARM1_HELD,
	output logic             LED_CLEAR,
	output logic      [15:0] DISPLAY_SOURCE,
	output logic      [2:0]  ALARM1_KIND,
	output src_sel_t         ALARM1_SOURCE,
	output src_sel_t         ALARM2_SOURCE
);
	logic [15:0]  disp_src_r;
	logic [15:0]  led_clear_r;
	logic [15:0]  a1_src_r;
	logic [15:0]  a1_kind_r;
	logic [15:0]  a1_on_dly_r;
	logic [15:0]  a1_off_dly_r;
	logic [15:0]  a1_rearm_r;
	logic [15:0]  a1_latch_r;
	logic [15:0]  a2_src_r;
	logic         wr_ok;
	logic         wr_bad;
	logic         mapped;
	logic [15:0]  rd_nxt;
	logic         clear_pulse;
	alarm_state_t state_r;
	logic [9:0]   sec_left_r;
	logic [31:0]  presc_r;
	logic         tick;
	logic         released;

	// Maps a source code onto the measurement register it reads.
	function automatic src_sel_t map_src(input logic [15:0] code);
		src_sel_t s;
		s.meas_addr    = 16'h0000;
		s.use_display2 = 1'b0;
		s.use_clock    = 1'b0;
		if (code[4:0] == SRC_DISP2) begin
			s.use_display2 = 1'b1;
		end else if (code[4:0] == SRC_CLOCK) begin
			s.use_clock = 1'b1;
		end else begin
			s.meas_addr = MEAS_BASE + code;
		end
		return s;
	endfunction

	// Range check per register except display source; the gap word takes writes silently.
	always_comb begin
		mapped = 1'b1;
		wr_bad = 1'b0;
		rd_nxt = 16'h0000;
		case (REG_ADDR)
			OFS_DISP_SRC: rd_nxt = disp_src_r;
			OFS_LED_CLEAR: begin
				rd_nxt = led_clear_r;
				wr_bad = REG_WDATA > MAX_FLAG;
			end
			OFS_A1_SRC: begin
				rd_nxt = a1_src_r;
				wr_bad = REG_WDATA > MAX_A1_SRC;
			end
			OFS_A1_KIND: begin
				rd_nxt = a1_kind_r;
				wr_bad = REG_WDATA > MAX_KIND;
			end
			OFS_A1_ON_DLY: begin
				rd_nxt = a1_on_dly_r;
				wr_bad = REG_WDATA > MAX_DELAY;
			end
			OFS_A1_OFF_DLY: begin
				rd_nxt = a1_off_dly_r;
				wr_bad = REG_WDATA > MAX_DELAY;
			end
			OFS_A1_REARM: begin
				rd_nxt = a1_rearm_r;
				wr_bad = REG_WDATA > MAX_DELAY;
			end
			OFS_A1_LATCH: begin
				rd_nxt = a1_latch_r;
				wr_bad = REG_WDATA > MAX_FLAG;
			end
			OFS_RSVD_GAP: rd_nxt = 16'h0000;
			OFS_A2_SRC: begin
				rd_nxt = a2_src_r;
				wr_bad = REG_WDATA > MAX_A2_SRC;
			end
			default: mapped = 1'b0;
		endcase
	end

	assign wr_ok = REG_WR && mapped && !wr_bad;
	assign clear_pulse = wr_ok && (REG_ADDR == OFS_LED_CLEAR) &&
		REG_WDATA[0];

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			disp_src_r   <= RST_DISP_SRC;
			led_clear_r  <= RST_LED_CLEAR;
			a1_src_r     <= RST_SRC;
			a1_kind_r    <= RST_KIND;
			a1_on_dly_r  <= RST_DELAY;
			a1_off_dly_r <= RST_DELAY;
			a1_rearm_r   <= RST_DELAY;
			a1_latch_r   <= RST_LATCH;
			a2_src_r     <= RST_SRC;
		end else if (wr_ok) begin
			case (REG_ADDR)
				OFS_DISP_SRC:   disp_src_r   <= REG_WDATA;
				OFS_LED_CLEAR:  led_clear_r  <= REG_WDATA;
				OFS_A1_SRC:     a1_src_r     <= REG_WDATA;
				OFS_A1_KIND:    a1_kind_r    <= REG_WDATA;
				OFS_A1_ON_DLY:  a1_on_dly_r  <= REG_WDATA;
				OFS_A1_OFF_DLY: a1_off_dly_r <= REG_WDATA;
				OFS_A1_REARM:   a1_rearm_r   <= REG_WDATA;
				OFS_A1_LATCH:   a1_latch_r   <= REG_WDATA;
				OFS_A2_SRC:     a2_src_r     <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// Bus answer: one cycle after the strobe, data and status registered.
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			REG_RDATA <= 16'h0000;
			REG_ACK   <= 1'b0;
			REG_ERR   <= 1'b0;
			LED_CLEAR <= 1'b0;
		end else begin
			REG_ACK   <= REG_WR || REG_RD;
			REG_ERR   <= (REG_WR && (wr_bad || !mapped)) ||
				(REG_RD && !mapped);
			LED_CLEAR <= clear_pulse;
			if (REG_RD) begin
				REG_RDATA <= rd_nxt;
			end
		end
	end

	// Configuration outputs, registered so the consumers see stable data.
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			DISPLAY_SOURCE <= RST_DISP_SRC;
			ALARM1_KIND    <= 3'h0;
			ALARM1_SOURCE  <= '0;
			ALARM2_SOURCE  <= '0;
		end else begin
			DISPLAY_SOURCE <= disp_src_r;
			ALARM1_KIND    <= a1_kind_r[2:0];
			ALARM1_SOURCE  <= map_src(a1_src_r);
			ALARM2_SOURCE  <= map_src(a2_src_r);
		end
	end

	assign tick = presc_r == 32'(SEC_CYC - 1);
	assign released = (state_r == A_ACTIVE && !ALARM1_TRIGGER &&
		a1_off_dly_r == 16'h0000) ||
		(state_r == A_OFF_WAIT && !ALARM1_TRIGGER && tick &&
		sec_left_r == 10'h001);

	// Alarm 1 timing. The second prescaler restarts on every load, so a
	// delay of N seconds lasts N whole seconds, never a partial first one.
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_r    <= A_IDLE;
			sec_left_r <= 10'h000;
			presc_r    <= 32'h0000_0000;
			ALARM1_RELAY <= 1'b0;
		end else begin
			presc_r <= tick ? 32'h0000_0000 : presc_r + 32'h0000_0001;
			case (state_r)
				A_IDLE: begin
					if (ALARM1_TRIGGER) begin
						presc_r    <= 32'h0000_0000;
						sec_left_r <= a1_on_dly_r[9:0];
						if (a1_on_dly_r == 16'h0000) begin
							state_r      <= A_ACTIVE;
							ALARM1_RELAY <= 1'b1;
						end else begin
							state_r <= A_ON_WAIT;
						end
					end
				end
				A_ON_WAIT: begin
					if (!ALARM1_TRIGGER) begin
						state_r <= A_IDLE;
					end else if (tick) begin
						sec_left_r <= sec_left_r - 10'h001;
						if (sec_left_r == 10'h001) begin
							state_r      <= A_ACTIVE;
							ALARM1_RELAY <= 1'b1;
						end
					end
				end
				A_ACTIVE: begin
					if (!ALARM1_TRIGGER) begin
						presc_r    <= 32'h0000_0000;
						sec_left_r <= a1_off_dly_r[9:0];
						if (a1_off_dly_r != 16'h0000) begin
							state_r <= A_OFF_WAIT;
						end
					end
				end
				A_OFF_WAIT: begin
					if (ALARM1_TRIGGER) begin
						state_r <= A_ACTIVE;
					end else if (tick) begin
						sec_left_r <= sec_left_r - 10'h001;
					end
				end
				A_LOCK: begin
					if (tick) begin
						sec_left_r <= sec_left_r - 10'h001;
						if (sec_left_r == 10'h001) begin
							state_r <= A_IDLE;
						end
					end
				end
				default: begin
					state_r      <= A_IDLE;
					ALARM1_RELAY <= 1'b0;
				end
			endcase
			if (released) begin
				ALARM1_RELAY <= 1'b0;
				presc_r      <= 32'h0000_0000;
				sec_left_r   <= a1_rearm_r[9:0];
				state_r <= (a1_rearm_r != 16'h0000) ? A_LOCK : A_IDLE;
			end
		end
	end

	// Held indication: a release in the same cycle as a clear still sets it.
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			ALARM1_HELD <= 1'b0;
		end else if (released && a1_latch_r[0]) begin
			ALARM1_HELD <= 1'b1;
		end else if (clear_pulse) begin
			ALARM1_HELD <= 1'b0;
		end
	end
endmodule

// ===== verification/alarm_cfg_sva.sv
// Port-level checker for the alarm configuration register group.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module alarm_cfg_sva
	import alarm_cfg_pkg::*;
#(
	parameter int SEC_CYC = 10
) (
	input wire logic        CORE_CLK,
	input wire logic        SYS_RST,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic        REG_ACK,
	input wire logic        REG_ERR,
	input wire logic        ALARM1_TRIGGER,
	input wire logic        ALARM1_RELAY,
	input wire logic        ALARM1_HELD,
	input wire logic        LED_CLEAR,
	input wire logic [15:0] DISPLAY_SOURCE,
	input wire logic [2:0]  ALARM1_KIND,
	input wire src_sel_t    ALARM1_SOURCE,
	input wire src_sel_t    ALARM2_SOURCE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	wire logic stb = REG_WR | REG_RD;
	wire logic wa1 = REG_WR && REG_ADDR == OFS_A1_SRC;
	wire logic wa2 = REG_WR && REG_ADDR == OFS_A2_SRC;
	wire logic wk = REG_WR && REG_ADDR == OFS_A1_KIND;
	ack_follows_a: assert property (stb |=> REG_ACK)
		else $error("no ack after strobe");
	ack_quiet_a: assert property (!stb |=> !REG_ACK)
		else $error("ack without strobe");
	disp_write_a: assert property (REG_WR && REG_ADDR == OFS_DISP_SRC |=>
		##1 DISPLAY_SOURCE == $past(REG_WDATA, 2)) else $error("display bad");
	led_pulse_a: assert property (REG_WR && REG_ADDR == OFS_LED_CLEAR
		&& REG_WDATA == 16'h0001 |=> LED_CLEAR) else $error("no clear pulse");
	held_clear_a: assert property (LED_CLEAR && !$fell(ALARM1_RELAY)
		|-> !ALARM1_HELD) else $error("held not cleared");
	held_set_a: assert property ($rose(ALARM1_HELD) |-> $fell(ALARM1_RELAY))
		else $error("held without release");
	a1_range_a: assert property (wa1 |=> REG_ERR ==
		($past(REG_WDATA) > MAX_A1_SRC)) else $error("a1 range");
	a2_range_a: assert property (wa2 |=> REG_ERR ==
		($past(REG_WDATA) > MAX_A2_SRC)) else $error("a2 range");
	kind_store_a: assert property (wk |=> ##1 ALARM1_KIND ==
		($past(REG_WDATA, 2) > MAX_KIND ? $past(ALARM1_KIND)
		: 3'($past(REG_WDATA, 2)))) else $error("kind bad");
	src_map_a: assert property (!$past(SYS_RST) && !ALARM1_SOURCE.use_clock
		&& !ALARM1_SOURCE.use_display2 |-> ALARM1_SOURCE.meas_addr
		- MEAS_BASE <= 16'h000e) else $error("source map");
	err_ack_a: assert property (REG_ERR |-> REG_ACK)
		else $error("err without ack");
	cover property (LED_CLEAR);
	cover property ($rose(ALARM1_RELAY));
	cover property ($rose(ALARM1_HELD));
endmodule

// ===== verification/alarm_config_registers_tb_top.sv
// Self-checking bench for the alarm configuration register group.
// Assumes a shortened second of SC cycles.
`timescale 1ns/1ps
module alarm_config_registers_tb_top;
	import alarm_cfg_pkg::*;
	localparam int SC = 10;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        trig = 1'b0;
	logic        wr, rd, ack, err, relay, held, clr, e;
	logic [15:0] addr, wdata, rdata, disp, q;
	logic [2:0]  kind;
	src_sel_t    s1, s2;
	int          err_count = 0;
	int          tests_run = 0;
	logic [15:0] rv [10] = '{RST_DISP_SRC, RST_LED_CLEAR, RST_SRC, RST_KIND,
		RST_DELAY, RST_DELAY, RST_DELAY, RST_LATCH, 16'h0000, RST_SRC};
	logic [15:0] mx [10] = '{16'hffff, MAX_FLAG, MAX_A1_SRC, MAX_KIND,
		MAX_DELAY, MAX_DELAY, MAX_DELAY, MAX_FLAG, 16'h0000, MAX_A2_SRC};
	always #20 clk = ~clk;
	alarm_config_registers #(.SEC_CYC(SC)) u_dut (.CORE_CLK(clk),
		.SYS_RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack), .REG_ERR(err),
		.ALARM1_TRIGGER(trig), .ALARM1_RELAY(relay), .ALARM1_HELD(held),
		.LED_CLEAR(clr), .DISPLAY_SOURCE(disp), .ALARM1_KIND(kind),
		.ALARM1_SOURCE(s1), .ALARM2_SOURCE(s2));
	reg_host_model u_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr),
		.wdata(wdata), .rdata(rdata), .ack(ack), .err(err));
	task automatic chk(input string n, input logic [15:0] x,
		input logic [15:0] g);
		tests_run++;
		if (g !== x) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", n, x, g);
		end
	endtask
	task automatic w(input logic [15:0] a, input logic [15:0] d, input logic x);
		u_host.xfer(1'b1, a, d, q, e);
		chk("write error", {15'h0, x}, {15'h0, e});
	endtask
	task automatic r(input logic [15:0] a, input logic [15:0] x);
		u_host.xfer(1'b0, a, 16'h0000, q, e);
		chk("read data", x, q);
	endtask
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		chk("display", RST_DISP_SRC, disp);
		for (int i = 0; i < 10; i++)
			r(OFS_DISP_SRC + 16'(i), rv[i]);
		for (int i = 0; i < 10; i++) begin
			if (i == 8)
				continue;
			w(OFS_DISP_SRC + 16'(i), mx[i], 1'b0);
			if (i > 0)
				w(OFS_DISP_SRC + 16'(i), mx[i] + 16'h0001, 1'b1);
			r(OFS_DISP_SRC + 16'(i), mx[i]);
		end
		chk("a1 clock", 16'h0001, 16'(s1.use_clock));
		chk("a2 addr", MEAS_BASE + 16'h000e, s2.meas_addr);
		chk("kind", 16'(MAX_KIND), 16'(kind));
		w(OFS_A1_SRC, 16'h0003, 1'b0);
		@(negedge clk);
		chk("a1 addr", MEAS_BASE + 16'h0003, s1.meas_addr);
		w(OFS_RSVD_GAP, 16'h00a5, 1'b0);
		r(OFS_RSVD_GAP, 16'h0000);
		w(16'h0fc2, 16'h0001, 1'b1);
		r(16'h0fc2, 16'h0000);
		chk("read error", 16'h0001, {15'h0, e});
		w(OFS_A1_ON_DLY, 16'h0002, 1'b0);
		w(OFS_A1_OFF_DLY, 16'h0000, 1'b0);
		w(OFS_A1_REARM, 16'h0001, 1'b0);
		@(posedge clk) trig <= 1'b1;
		repeat (2 * SC - 2) @(negedge clk);
		chk("relay early", 16'h0000, 16'(relay));
		repeat (6) @(negedge clk);
		chk("relay on", 16'h0001, 16'(relay));
		// A zero on delay makes the lock the only thing holding the relay off.
		w(OFS_A1_ON_DLY, 16'h0000, 1'b0);
		@(posedge clk) trig <= 1'b0;
		repeat (3) @(negedge clk);
		chk("relay off", 16'h0000, 16'(relay));
		chk("held", 16'h0001, 16'(held));
		@(posedge clk) trig <= 1'b1;
		repeat (5) @(negedge clk);
		chk("relay locked", 16'h0000, 16'(relay));
		@(posedge clk) trig <= 1'b0;
		w(OFS_LED_CLEAR, 16'h0000, 1'b0);
		@(negedge clk);
		chk("held kept", 16'h0001, 16'(held));
		w(OFS_LED_CLEAR, 16'h0001, 1'b0);
		@(negedge clk);
		chk("held cleared", 16'h0000, 16'(held));
		w(OFS_A1_LATCH, 16'h0000, 1'b0);
		w(OFS_A1_ON_DLY, 16'h0000, 1'b0);
		repeat (12) @(posedge clk);
		trig <= 1'b1;
		repeat (3) @(negedge clk);
		chk("relay prompt", 16'h0001, 16'(relay));
		@(posedge clk) trig <= 1'b0;
		repeat (3) @(negedge clk);
		chk("no latch", 16'h0000, 16'(held));
		end_sim();
	end
endmodule
bind alarm_config_registers alarm_cfg_sva #(.SEC_CYC(SEC_CYC)) u_sva (
	.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_ACK(REG_ACK), .REG_ERR(REG_ERR), .ALARM1_TRIGGER(ALARM1_TRIGGER),
	.ALARM1_RELAY(ALARM1_RELAY), .ALARM1_HELD(ALARM1_HELD),
	.LED_CLEAR(LED_CLEAR), .DISPLAY_SOURCE(DISPLAY_SOURCE),
	.ALARM1_KIND(ALARM1_KIND), .ALARM1_SOURCE(ALARM1_SOURCE),
	.ALARM2_SOURCE(ALARM2_SOURCE));

// ===== verification/reg_host_model.sv
// Host model issuing single-strobe register transfers.
// Assumes the one-cycle acknowledge of the register port.
`timescale 1ns/1ps
module reg_host_model (
	input  wire logic        clk,
	output logic             wr,
	output logic             rd,
	output logic      [15:0] addr,
	output logic      [15:0] wdata,
	input  wire logic [15:0] rdata,
	input  wire logic        ack,
	input  wire logic        err
);
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 16'h0000;
		wdata = 16'h0000;
	end
	// Released address and data lines are inverted so stale values cannot pass as valid.
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic e);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
		@(posedge clk);
		q = rdata;
		e = ack ? err : 1'bx;
	endtask
endmodule
